// >>> hdl/dpr_engine.sv
`timescale 1ns/10ps
// ==============================================================
// Recursive PID arithmetic, one update per tick
module dpr_engine #(
    parameter int DW = 13,
    parameter int GW = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Sample
    input wire logic tick,
    input wire logic run,
    input wire logic [DW-1:0] sp,
    input wire logic [DW-1:0] pv,
    input wire logic [GW-1:0] kp,
    input wire logic [GW-1:0] ki,
    input wire logic [GW-1:0] kd,
    // Result
    output logic [DW-1:0] y
);
    import dpr_pkg::*;

    localparam int EW = DW + 1;
    // Holds Kp*Ki*e with both gains carrying the 4096 scale, plus sign and sum headroom
    localparam int AW = EW + 2 * GW + 4;

    logic signed [EW-1:0] e1_r, e1_nxt, e2_r, e2_nxt;
    logic [DW-1:0] y_r, y_nxt;
    logic signed [EW-1:0] e0;
    logic signed [AW-1:0] dp, di, dd, acc, ysum;

    initial begin
        if (DW < 2 || GW < DPR_GAIN_FRAC + 1) $error("dpr_engine width too small");
    end

    always_comb begin
        e0 = EW'($signed({1'b0, sp})) - EW'($signed({1'b0, pv}));
        dp = AW'(e0) - AW'(e1_r);
        di = AW'(e1_r);
        dd = AW'(e0) - AW'(e1_r) - AW'(e1_r) + AW'(e2_r);
        // Error step carries the 4096 scale too, so all three terms share one shift
        acc = AW'($signed({1'b0, kp})) * ((dp <<< DPR_GAIN_FRAC) + AW'($signed({1'b0, ki})) * di
            + AW'($signed({1'b0, kd})) * dd);
        ysum = AW'($signed({1'b0, y_r})) + (acc >>> (2 * DPR_GAIN_FRAC));
        e1_nxt = e1_r;
        e2_nxt = e2_r;
        y_nxt = y_r;
        if (tick) begin
            e1_nxt = e0;
            e2_nxt = e1_r;
            if (!run) y_nxt = pv;
            else if (ysum < 0) y_nxt = '0;
            else if (ysum > AW'($signed({1'b0, {DW{1'b1}}}))) y_nxt = {DW{1'b1}};
            else y_nxt = ysum[DW-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            e1_r <= '0;
            e2_r <= '0;
            y_r <= '0;
        end else begin
            e1_r <= e1_nxt;
            e2_r <= e2_nxt;
            y_r <= y_nxt;
        end
    end

    assign y = y_r;

    history_shift_a:
    assert property (@(posedge clk) disable iff (!rst_n) tick |=> e2_r == $past(e1_r))
        else $error("error history not shifted");
    hold_between_a:
    assert property (@(posedge clk) disable iff (!rst_n) !tick |=> $stable(y_r))
        else $error("output moved without tick");

endmodule : dpr_engine

// >>> hdl/dpr_pkg.sv
package dpr_pkg;

    // ==============================================================
    // Widths and scaling
    localparam int DPR_DW = 13;
    localparam int DPR_GAIN_W = 16;
    localparam int DPR_GAIN_FRAC = 12;
    localparam logic [12:0] DPR_OUT_MAX = 13'h1FFF;

    // ==============================================================
    // Timing
    localparam int DPR_CLK_HZ = 10000000;
    localparam int DPR_PERIOD_US = 20000;
    localparam int DPR_PERIOD_CYC = DPR_PERIOD_US * (DPR_CLK_HZ / 1000000);

    // ==============================================================
    // Register offsets (byte addresses)
    localparam logic [7:0] DPR_A_CTRL = 8'h00;
    localparam logic [7:0] DPR_A_KP = 8'h04;
    localparam logic [7:0] DPR_A_KI = 8'h08;
    localparam logic [7:0] DPR_A_KD = 8'h0C;
    localparam logic [7:0] DPR_A_KEYSP = 8'h10;
    localparam logic [7:0] DPR_A_THR = 8'h14;
    localparam logic [7:0] DPR_A_STAT = 8'h18;
    localparam logic [7:0] DPR_A_PV = 8'h1C;
    localparam logic [7:0] DPR_A_OUT = 8'h20;

    // ==============================================================
    // Control field positions and codes
    localparam int DPR_F_FUNC = 0;
    localparam int DPR_F_SRC = 4;
    localparam int DPR_F_FBSEL = 8;
    localparam logic [3:0] DPR_FUNC_A = 4'h1;
    localparam logic [3:0] DPR_FUNC_B = 4'h3;
    localparam logic [3:0] DPR_SRC_KEYPAD = 4'h0;
    localparam logic [4:0] DPR_DI3_MANAUTO = 5'h0F;
    localparam logic [31:0] DPR_CTRL_RST = 32'h0000_0000;
    localparam logic [15:0] DPR_GAIN_RST = 16'h0000;

    typedef struct packed {
        logic [12:0] a1;
        logic [12:0] a2;
        logic [12:0] a3;
        logic [12:0] a4;
        logic [12:0] a5;
        logic [12:0] multispeed;
        logic [12:0] serial;
        logic [12:0] fieldbus;
    } dpr_sources_s;

endpackage : dpr_pkg

// >>> hdl/dpr_top.sv
// Implementation choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
// Functional notes
// - New output once every 20 ms
// - Recursive PID incremental update equation
// - Gains fixed point scaled by 4096
// - Setpoint unsigned 13 bits
// - Feedback from one of two inputs
// - Output limited to 13 bits
// - Error is setpoint minus feedback, keep history
// - Active only for function 1 or 3
// - Input low manual, high automatic
// - Activation sets third input code 15
// - Manual to auto loads keypad setpoint when keypad is the source
// - Jog and direction disabled while active
// - Threshold outputs above upper, below lower
// - Setpoint source selectable among many
// - Feedback value readable
// - Automatic output replaces speed reference
// - Setting selects feedback analog input
module dpr_top #(
    parameter int PERIOD_CYC = dpr_pkg::DPR_PERIOD_CYC
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESETN,
    // AXI4-Lite write
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // AXI4-Lite read
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // Process signals
    input wire dpr_pkg::dpr_sources_s SP_SOURCES,
    input wire logic [12:0] SECOND_ANALOG_INPUT,
    input wire logic [12:0] THIRD_ANALOG_INPUT,
    input wire logic MANUAL_AUTO_SELECT_INPUT,
    input wire logic [12:0] SPEED_REF_IN,
    // Outputs
    output logic [12:0] SPEED_REF_OUT,
    output logic UPPER_THRESHOLD_VALUE,
    output logic LOWER_THRESHOLD_VALUE,
    output logic JOG_DIR_INHIBIT,
    output logic [4:0] THIRD_INPUT_FUNCTION_CODE,
    output logic SAMPLE_TICK
);
    import dpr_pkg::*;

    initial begin
        if (PERIOD_CYC < 2) $error("PERIOD_CYC too small");
    end

    // ==============================================================
    // Registers
    logic [31:0] ctrl_r, ctrl_nxt;
    logic [15:0] kp_r, kp_nxt, ki_r, ki_nxt, kd_r, kd_nxt;
    logic [12:0] keysp_r, keysp_nxt, upper_r, upper_nxt, lower_r, lower_nxt;
    logic [4:0] di3_r, di3_nxt;
    logic aw_r, aw_nxt, w_r, w_nxt, b_r, b_nxt, r_r, r_nxt;
    logic [7:0] awa_r, awa_nxt;
    logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic tick_r, tick_nxt, auto_r, auto_nxt;

    logic [3:0] func_sel, src_sel;
    logic fb_sel, active, automatic_on, to_auto, do_write;
    logic [12:0] pv, sp, y;

    assign func_sel = ctrl_r[DPR_F_FUNC +: 4];
    assign src_sel = ctrl_r[DPR_F_SRC +: 4];
    assign fb_sel = ctrl_r[DPR_F_FBSEL];
    assign active = (func_sel == DPR_FUNC_A) || (func_sel == DPR_FUNC_B);
    assign automatic_on = active && MANUAL_AUTO_SELECT_INPUT;
    assign to_auto = automatic_on && !auto_r;
    assign pv = fb_sel ? THIRD_ANALOG_INPUT : SECOND_ANALOG_INPUT;

    // ==============================================================
    // Setpoint source
    // Setpoint mux
    always_comb begin
        logic [13:0] sum;
        sum = {1'b0, SP_SOURCES.a1} + {1'b0, SP_SOURCES.a2};
        unique case (src_sel)
            4'h0: sp = keysp_r;
            4'h1: sp = SP_SOURCES.a1;
            4'h2: sp = SP_SOURCES.a2;
            4'h3: sp = SP_SOURCES.a3;
            4'h4: sp = SP_SOURCES.a4;
            4'h5: sp = SP_SOURCES.a5;
            4'h6: sp = sum[13] ? 13'h1FFF : sum[12:0];
            4'h8: sp = SP_SOURCES.multispeed;
            4'h9: sp = SP_SOURCES.serial;
            4'hA: sp = SP_SOURCES.fieldbus;
            default: sp = keysp_r;
        endcase
    end

    // ==============================================================
    // Sample timer and PID engine
    // 20 ms tick
    always_comb begin
        tick_nxt = (cnt_r == 32'(PERIOD_CYC - 1));
        cnt_nxt = tick_nxt ? 32'h0000_0000 : cnt_r + 32'h0000_0001;
        auto_nxt = automatic_on;
    end

    dpr_engine #(.DW(DPR_DW), .GW(DPR_GAIN_W)) u_engine (
        .clk(CLK),
        .rst_n(RESETN),
        .tick(tick_r),
        .run(automatic_on),
        .sp(sp),
        .pv(pv),
        .kp(kp_r),
        .ki(ki_r),
        .kd(kd_r),
        .y(y)
    );

    // ==============================================================
    // AXI4-Lite slave
    always_comb begin
        aw_nxt = aw_r;
        w_nxt = w_r;
        awa_nxt = awa_r;
        wd_nxt = wd_r;
        b_nxt = b_r;
        bresp_nxt = bresp_r;
        r_nxt = r_r;
        rd_nxt = rd_r;
        rresp_nxt = rresp_r;
        ctrl_nxt = ctrl_r;
        kp_nxt = kp_r;
        ki_nxt = ki_r;
        kd_nxt = kd_r;
        keysp_nxt = keysp_r;
        upper_nxt = upper_r;
        lower_nxt = lower_r;
        di3_nxt = di3_r;
        do_write = aw_r && w_r && !b_r;
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_nxt = 1'b1;
            awa_nxt = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_nxt = 1'b1;
            wd_nxt = S_AXI_WDATA;
        end
        if (do_write) begin
            aw_nxt = 1'b0;
            w_nxt = 1'b0;
            b_nxt = 1'b1;
            bresp_nxt = 2'b00;
            unique case (awa_r)
                DPR_A_CTRL: ctrl_nxt = wd_r;
                DPR_A_KP: kp_nxt = wd_r[15:0];
                DPR_A_KI: ki_nxt = wd_r[15:0];
                DPR_A_KD: kd_nxt = wd_r[15:0];
                DPR_A_KEYSP: keysp_nxt = wd_r[12:0];
                DPR_A_THR: begin
                    upper_nxt = wd_r[12:0];
                    lower_nxt = wd_r[28:16];
                end
                default: bresp_nxt = 2'b10;
            endcase
        end
        if (b_r && S_AXI_BREADY) b_nxt = 1'b0;
        if (to_auto && src_sel == DPR_SRC_KEYPAD) keysp_nxt = pv;
        if (active) di3_nxt = DPR_DI3_MANAUTO;
        if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            r_nxt = 1'b1;
            rresp_nxt = 2'b00;
            unique case (S_AXI_ARADDR)
                DPR_A_CTRL: rd_nxt = ctrl_r;
                DPR_A_KP: rd_nxt = {16'h0000, kp_r};
                DPR_A_KI: rd_nxt = {16'h0000, ki_r};
                DPR_A_KD: rd_nxt = {16'h0000, kd_r};
                DPR_A_KEYSP: rd_nxt = {19'h00000, keysp_r};
                DPR_A_THR: rd_nxt = {3'h0, lower_r, 3'h0, upper_r};
                DPR_A_STAT: rd_nxt = {24'h000000, 3'h0, di3_r[4:0] == DPR_DI3_MANAUTO,
                    LOWER_THRESHOLD_VALUE, UPPER_THRESHOLD_VALUE, automatic_on, active};
                DPR_A_PV: rd_nxt = {19'h00000, pv};
                DPR_A_OUT: rd_nxt = {19'h00000, y};
                default: begin
                    rd_nxt = 32'h0000_0000;
                    rresp_nxt = 2'b10;
                end
            endcase
        end else if (r_r && S_AXI_RREADY) begin
            r_nxt = 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ctrl_r <= DPR_CTRL_RST;
            kp_r <= DPR_GAIN_RST;
            ki_r <= DPR_GAIN_RST;
            kd_r <= DPR_GAIN_RST;
            keysp_r <= 13'h0000;
            upper_r <= DPR_OUT_MAX;
            lower_r <= 13'h0000;
            di3_r <= 5'h00;
            aw_r <= 1'b0;
            w_r <= 1'b0;
            b_r <= 1'b0;
            r_r <= 1'b0;
            awa_r <= 8'h00;
            wd_r <= 32'h0000_0000;
            rd_r <= 32'h0000_0000;
            bresp_r <= 2'b00;
            rresp_r <= 2'b00;
            cnt_r <= 32'h0000_0000;
            tick_r <= 1'b0;
            auto_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            kp_r <= kp_nxt;
            ki_r <= ki_nxt;
            kd_r <= kd_nxt;
            keysp_r <= keysp_nxt;
            upper_r <= upper_nxt;
            lower_r <= lower_nxt;
            di3_r <= di3_nxt;
            aw_r <= aw_nxt;
            w_r <= w_nxt;
            b_r <= b_nxt;
            r_r <= r_nxt;
            awa_r <= awa_nxt;
            wd_r <= wd_nxt;
            rd_r <= rd_nxt;
            bresp_r <= bresp_nxt;
            rresp_r <= rresp_nxt;
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
            auto_r <= auto_nxt;
        end
    end

    assign S_AXI_AWREADY = !aw_r && !b_r;
    assign S_AXI_WREADY = !w_r && !b_r;
    assign S_AXI_BVALID = b_r;
    assign S_AXI_BRESP = bresp_r;
    assign S_AXI_ARREADY = !r_r;
    assign S_AXI_RVALID = r_r;
    assign S_AXI_RDATA = rd_r;
    assign S_AXI_RRESP = rresp_r;

    // ==============================================================
    // Outputs
    // Automatic output replaces reference
    assign SPEED_REF_OUT = automatic_on ? y : SPEED_REF_IN;
    assign UPPER_THRESHOLD_VALUE = pv > upper_r;
    assign LOWER_THRESHOLD_VALUE = pv < lower_r;
    assign JOG_DIR_INHIBIT = active;
    assign THIRD_INPUT_FUNCTION_CODE = di3_r;
    assign SAMPLE_TICK = tick_r;

    // ==============================================================
    // Checks
    sequence to_auto_keypad_s;
        to_auto && src_sel == DPR_SRC_KEYPAD;
    endsequence

    bumpless_load_a:
    assert property (@(posedge CLK) disable iff (!RESETN) to_auto_keypad_s |=> keysp_r == $past(pv))
        else $error("keypad setpoint not loaded");
    tick_spacing_a:
    assert property (@(posedge CLK) disable iff (!RESETN) tick_r |=> !tick_r)
        else $error("ticks back to back");
    inactive_pass_a:
    assert property (@(posedge CLK) disable iff (!RESETN) !active |-> SPEED_REF_OUT == SPEED_REF_IN)
        else $error("inactive regulator touched reference");
    auto_replace_a:
    assert property (@(posedge CLK) disable iff (!RESETN) automatic_on |-> SPEED_REF_OUT == y)
        else $error("automatic output not used");
    di3_code_a:
    assert property (@(posedge CLK) disable iff (!RESETN) active |=> di3_r == 5'h0F)
        else $error("third input code not 15");
    manual_sel_a:
    assert property (@(posedge CLK) disable iff (!RESETN)
        active && !MANUAL_AUTO_SELECT_INPUT |-> !automatic_on)
        else $error("low input did not select manual");
    upper_thr_a:
    assert property (@(posedge CLK) disable iff (!RESETN)
        UPPER_THRESHOLD_VALUE |-> pv > upper_r)
        else $error("upper threshold wrong");
    jog_inhibit_a:
    assert property (@(posedge CLK) disable iff (!RESETN) active |-> JOG_DIR_INHIBIT)
        else $error("jog not inhibited");

endmodule : dpr_top

// >>> tb/discrete_pid_process_regulator_tb.sv
`timescale 1ns/10ps
module discrete_pid_process_regulator_tb;
    import dpr_pkg::*;
    localparam int PER = 40;
    logic CLK = 1'b0;
    logic RESETN = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, up, lo, inh, tick, mai = 1'b0;
    logic [1:0] bresp, rresp;
    logic [12:0] pv_req = 13'h0000, spd_out, spd_in, fb2, fb3;
    logic [4:0] code;
    dpr_sources_s srcs;
    logic [12:0] exp_q[$];
    logic [12:0] tv[4] = '{13'h007F, 13'h0080, 13'h0200, 13'h0201};
    longint kp_m = 0, ki_m = 0, kd_m = 0, acc;
    int y_m = 0, e1_m = 0, e2_m = 0, sp_m = 0, e, gap = 0, cyc = 0;
    int fails = 0, samples_checked = 0;
    int seed = 32'h5a96857c;
    logic tick_q = 1'b0, seen = 1'b0;

    always #50 CLK = ~CLK;

    dpr_top #(.PERIOD_CYC(PER)) dpr_top_i (.CLK(CLK), .RESETN(RESETN),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
        .SP_SOURCES(srcs), .SECOND_ANALOG_INPUT(fb2), .THIRD_ANALOG_INPUT(fb3),
        .MANUAL_AUTO_SELECT_INPUT(mai), .SPEED_REF_IN(spd_in), .SPEED_REF_OUT(spd_out),
        .UPPER_THRESHOLD_VALUE(up), .LOWER_THRESHOLD_VALUE(lo), .JOG_DIR_INHIBIT(inh),
        .THIRD_INPUT_FUNCTION_CODE(code), .SAMPLE_TICK(tick));

    dpr_plant_model dpr_plant_model_i (.pv_req(pv_req), .sources(srcs), .fb_second(fb2),
        .fb_third(fb3), .speed_ref(spd_in));

    // ==============================================================
    // Checking and closing
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        samples_checked++;
        if (g !== x) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, g, x);
        end
    endtask : chk

    task automatic test_done;
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : test_done

    // ==============================================================
    // Register bus master
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        @(posedge CLK);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge CLK);
            if (awready && awvalid) awvalid <= 1'b0;
            if (wready && wvalid) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk(bresp, er);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] v);
        @(posedge CLK);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge CLK);
            if (arready && arvalid) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        v = rdata;
        rready <= 1'b0;
        chk(rresp, er);
    endtask : rd

    task automatic wait_tick;
        do @(posedge CLK); while (tick !== 1'b1);
    endtask : wait_tick

    // ==============================================================
    // Reference regulator, one note per automatic sample
    always @(posedge CLK) begin
        if (!RESETN) begin
            y_m = 0;
            e1_m = 0;
            e2_m = 0;
        end else if (tick === 1'b1) begin
            e = sp_m - int'(pv_req);
            acc = kp_m * (4096 * longint'(e - e1_m) + ki_m * e1_m + kd_m * (e - 2 * e1_m + e2_m));
            y_m = mai ? y_m + int'(acc >>> 24) : int'(pv_req);
            y_m = y_m < 0 ? 0 : (y_m > 8191 ? 8191 : y_m);
            e2_m = e1_m;
            e1_m = e;
            if (mai) exp_q.push_back(13'(y_m));
        end
    end

    // Output watcher
    always @(posedge CLK) begin
        cyc++;
        gap++;
        if (tick_q && exp_q.size() > 0) chk(spd_out, exp_q.pop_front()); // recursion
        if (tick === 1'b1) begin
            if (seen) chk(gap, PER); // sample spacing
            seen = 1'b1;
            gap = 0;
        end
        tick_q = tick;
        if (cyc > 20000) begin
            fails++;
            test_done();
        end
    end

    // ==============================================================
    // Main sequence
    initial begin
        repeat (6) @(posedge CLK);
        RESETN <= 1'b1;
        rd(DPR_A_OUT, 2'b00, d);
        chk(d, 0); // output cleared
        rd(8'h3C, 2'b10, d);
        wr(8'h40, 32'h1, 2'b10);
        for (int f = 0; f < 5; f++) begin
            wr(DPR_A_CTRL, 32'h100 | f, 2'b00); // functions zero to four, third input feedback
            chk(inh, f == 1 || f == 3); // activity gating
        end
        chk(code, DPR_DI3_MANAUTO); // selector code
        pv_req <= 13'd300;
        rd(DPR_A_PV, 2'b00, d);
        chk(d[12:0], 13'd300 ^ 13'h1555); // third input
        wr(DPR_A_CTRL, 32'h0, 2'b00);
        rd(DPR_A_PV, 2'b00, d);
        chk(d[12:0], 13'd300); // second input
        wr(DPR_A_THR, 32'h0080_0200, 2'b00);
        foreach (tv[i]) begin
            pv_req <= tv[i];
            repeat (2) @(posedge CLK);
            chk({up, lo}, {tv[i] > 13'h0200, tv[i] < 13'h0080}); // threshold flags
        end
        for (int r = 0; r < 3; r++) begin
            wait_tick();
            @(posedge CLK);
            kp_m = r == 2 ? longint'($random(seed) & 32'hFFFF) : 4096 * (r + 1);
            ki_m = r == 2 ? longint'($random(seed) & 32'hFFFF) : 1024 / (r + 1);
            kd_m = r == 2 ? longint'($random(seed) & 32'hFFFF) : 2048 * r;
            wr(DPR_A_KP, 32'(kp_m), 2'b00);
            wr(DPR_A_KI, 32'(ki_m), 2'b00);
            wr(DPR_A_KD, 32'(kd_m), 2'b00);
            wr(DPR_A_KEYSP, 32'h0400, 2'b00);
            wr(DPR_A_CTRL, r == 1 ? 32'h00A1 : 32'h0003, 2'b00); // source choice
            sp_m = r == 1 ? 32'h0800 : 32'h0400;
            repeat (3) wait_tick();
            @(posedge CLK);
            mai <= 1'b1;
            if (r != 1) begin
                sp_m = int'(pv_req);
                repeat (2) @(posedge CLK);
                rd(DPR_A_KEYSP, 2'b00, d);
                chk(d[12:0], pv_req); // bumpless load
                wr(DPR_A_KEYSP, r == 0 ? 32'h0600 : 32'h1FFF, 2'b00); // new setpoint, 0x0600 on the first run, full scale on the last
                sp_m = r == 0 ? 32'h0600 : 32'h1FFF;
            end
            repeat (8) begin
                wait_tick();
                pv_req <= 13'($random(seed));
            end
            repeat (2) @(posedge CLK);
            mai <= 1'b0;
            repeat (2) @(posedge CLK);
            chk(spd_out, spd_in); // manual passthrough
        end
        test_done();
    end
endmodule : discrete_pid_process_regulator_tb

// >>> tb/dpr_plant_model.sv
`timescale 1ns/10ps
// ==============================================================
// Process sensors and reference path
module dpr_plant_model (
    // Requested process value
    input wire logic [12:0] pv_req,
    // Process side
    output dpr_pkg::dpr_sources_s sources,
    output logic [12:0] fb_second,
    output logic [12:0] fb_third,
    output logic [12:0] speed_ref
);
    import dpr_pkg::*;
    // Third sensor shows an XOR pattern so a wrong selection is seen
    assign fb_second = pv_req;
    assign fb_third = pv_req ^ 13'h1555;
    assign speed_ref = ~pv_req;
    assign sources = {13'h0100, 13'h0200, 13'h0300, 13'h0400,
                      13'h0500, 13'h0600, 13'h0700, 13'h0800};
endmodule : dpr_plant_model
